// file: shared/pss_regs.svh
// Register offsets, field positions and fixed values of the power switch stream status block.
// Assumes byte addressing on a 32-bit Avalon-MM slave port.
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PSS_STATUS_OFS     4'h0
`define PSS_CTRL_OFS       4'h4

// ****************************************************************
// Status field positions
// ****************************************************************
`define PSS_RSVD_BIT       12
`define PSS_BUSY_BIT       11
`define PSS_RISE_BIT       10
`define PSS_FALL_BIT       9
`define PSS_FLAG_BASE      9
`define PSS_NFLAGS         3
`define PSS_FLAG_FALL_IDX  0
`define PSS_FLAG_RISE_IDX  1
`define PSS_FLAG_BUSY_IDX  2
`define PSS_RSVD_VAL       1'b1

// ****************************************************************
// Command field positions and reset values
// ****************************************************************
`define PSS_CTRL_UP_BIT    0
`define PSS_CTRL_DOWN_BIT  1
`define PSS_RDATA_RST      32'h0000_0000
`define PSS_WAIT_RST       1'b1

`endif

// file: shared/pss_pkg.sv
// Types shared by the power switch stream status block and its helpers.
// Assumes the widths below match the 32-bit Avalon-MM slave port.
package pss_pkg;

  // ****************************************************************
  // Bus carriers
  // ****************************************************************
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } pss_avs_req_t;

  // ****************************************************************
  // Stream events from the serializer and settle timers
  // ****************************************************************
  typedef struct packed {
    logic start;
    logic dir_up;
    logic done;
    logic rise_expired;
    logic fall_expired;
  } pss_stream_ev_t;

  // ****************************************************************
  // Module state records
  // ****************************************************************
  typedef struct packed {
    logic waitreq;
  } pss_avs_state_t;

  typedef struct packed {
    logic flag;
  } pss_flag_state_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic        rise_req;
    logic        fall_req;
    logic        dir_up;
  } pss_top_state_t;

endpackage : pss_pkg

// file: hdl/pss_avs.sv
// Avalon-MM handshake for the status block: one wait cycle, then one ready cycle.
// Assumes the master holds read or write steady until it sees waitrequest low.
`timescale 1ns/1ps

`include "pss_regs.svh"

module pss_avs (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic req_in,
  output logic      waitrequest_out,
  output logic      capture_out,
  output logic      take_out
);

  pss_pkg::pss_avs_state_t state_q;
  pss_pkg::pss_avs_state_t state_d;

  // ****************************************************************
  // Handshake
  // ****************************************************************
  // The wait cycle lets read data come from a flop while the master still waits.
  always_comb
  begin
    state_d         = state_q;
    state_d.waitreq = !(req_in && state_q.waitreq);
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q.waitreq <= `PSS_WAIT_RST;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign waitrequest_out = state_q.waitreq;
  assign capture_out     = req_in && state_q.waitreq;
  assign take_out        = req_in && !state_q.waitreq;

endmodule : pss_avs

// file: hdl/pss_flag.sv
// One hardware-owned status flag with set and clear events.
// Assumes both events are single-cycle pulses on the same clock.
`timescale 1ns/1ps

module pss_flag (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_out
);

  pss_pkg::pss_flag_state_t state_q;
  pss_pkg::pss_flag_state_t state_d;

  // ****************************************************************
  // Flag update
  // ****************************************************************
  // A set arriving with a clear wins, so no event is lost.
  always_comb
  begin
    state_d = state_q;
    if (set_in)
    begin
      state_d.flag = 1'b1;
    end
    else if (clr_in)
    begin
      state_d.flag = 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q.flag <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign flag_out = state_q.flag;

endmodule : pss_flag

// file: hdl/pss_status.sv
// Status bank of the socket power switch stream, reached over Avalon-MM with waitrequest.
// Assumes the serializer and settle timers run on clk_in and pulse their events for one cycle.
`timescale 1ns/1ps

`include "pss_regs.svh"

module pss_status (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Avalon-MM slave.
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Serializer and settle timer events.
  input  wire logic        stream_start_in,
  input  wire logic        stream_dir_up_in,
  input  wire logic        stream_done_in,
  input  wire logic        rise_expired_in,
  input  wire logic        fall_expired_in,
  // Software stream requests towards the serializer.
  output logic             rise_req_out,
  output logic             fall_req_out,
  // Status flags for the rest of the controller.
  output logic             switch_stream_busy_out,
  output logic             rise_settle_pending_out,
  output logic             fall_settle_pending_out
);

  // ****************************************************************
  // Carriers
  // ****************************************************************
  pss_pkg::pss_avs_req_t   bus;
  pss_pkg::pss_stream_ev_t ev;
  pss_pkg::pss_top_state_t state_q;
  pss_pkg::pss_top_state_t state_d;

  logic                    capture;
  logic                    take;
  logic [`PSS_NFLAGS-1:0]  flag_set;
  logic [`PSS_NFLAGS-1:0]  flag_clr;
  logic [`PSS_NFLAGS-1:0]  flags;
  logic [31:0]             status_word;
  logic                    ctrl_write;

  assign bus.read       = avs_read_in;
  assign bus.write      = avs_write_in;
  assign bus.address    = avs_address_in;
  assign bus.writedata  = avs_writedata_in;
  assign bus.byteenable = avs_byteenable_in;

  assign ev.start        = stream_start_in;
  assign ev.dir_up       = stream_dir_up_in;
  assign ev.done         = stream_done_in;
  assign ev.rise_expired = rise_expired_in;
  assign ev.fall_expired = fall_expired_in;

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  pss_avs u_avs (
    .clk_in          (clk_in),
    .rst_in          (rst_in),
    .req_in          (bus.read || bus.write),
    .waitrequest_out (avs_waitrequest_out),
    .capture_out     (capture),
    .take_out        (take)
  );

  // ****************************************************************
  // Status flags
  // ****************************************************************
  // Busy follows the stream itself; a new start in the done cycle keeps it set.
  assign flag_set[`PSS_FLAG_BUSY_IDX] = ev.start;
  assign flag_clr[`PSS_FLAG_BUSY_IDX] = ev.done;

  // The direction is latched at start because the serializer need not hold it.
  assign flag_set[`PSS_FLAG_RISE_IDX] = ev.done && state_q.dir_up;
  assign flag_clr[`PSS_FLAG_RISE_IDX] = ev.rise_expired;

  assign flag_set[`PSS_FLAG_FALL_IDX] = ev.done && !state_q.dir_up;
  assign flag_clr[`PSS_FLAG_FALL_IDX] = ev.fall_expired;

  generate
    for (genvar i = 0; i < `PSS_NFLAGS; i++)
    begin : g_flag
      pss_flag u_flag (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .set_in   (flag_set[i]),
        .clr_in   (flag_clr[i]),
        .flag_out (flags[i])
      );
    end
  endgenerate

  // ****************************************************************
  // Read view
  // ****************************************************************
  always_comb
  begin
    status_word                                             = 32'h0000_0000;
    status_word[`PSS_RSVD_BIT]                              = `PSS_RSVD_VAL;
    status_word[`PSS_FLAG_BASE +: `PSS_NFLAGS]              = flags;
  end

  // Only the command word accepts writes; the status word has no writable bit.
  assign ctrl_write = take && bus.write && (bus.address == `PSS_CTRL_OFS)
                      && bus.byteenable[0];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    state_d          = state_q;
    state_d.rise_req = 1'b0;
    state_d.fall_req = 1'b0;
    if (ev.start)
    begin
      state_d.dir_up = ev.dir_up;
    end
    if (capture && bus.read)
    begin
      if (bus.address == `PSS_STATUS_OFS)
      begin
        state_d.rdata = status_word;
      end
      else
      begin
        state_d.rdata = 32'h0000_0000;
      end
    end
    // A request while a stream runs would overlap frames on the switch, so it is dropped.
    if (ctrl_write && !flags[`PSS_FLAG_BUSY_IDX])
    begin
      state_d.rise_req = bus.writedata[`PSS_CTRL_UP_BIT];
      state_d.fall_req = bus.writedata[`PSS_CTRL_DOWN_BIT]
                         && !bus.writedata[`PSS_CTRL_UP_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q.rdata    <= `PSS_RDATA_RST;
      state_q.rise_req <= 1'b0;
      state_q.fall_req <= 1'b0;
      state_q.dir_up   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign avs_readdata_out        = state_q.rdata;
  assign rise_req_out            = state_q.rise_req;
  assign fall_req_out            = state_q.fall_req;
  assign switch_stream_busy_out  = flags[`PSS_FLAG_BUSY_IDX];
  assign rise_settle_pending_out = flags[`PSS_FLAG_RISE_IDX];
  assign fall_settle_pending_out = flags[`PSS_FLAG_FALL_IDX];

endmodule : pss_status

// file: bench/pss_status_properties.sv
// Port checks for the status block.
// Assumes it is bound to pss_status.
`timescale 1ns/1ps
module pss_status_properties (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        stream_start_in,
  input wire logic        stream_dir_up_in,
  input wire logic        stream_done_in,
  input wire logic        rise_expired_in,
  input wire logic        fall_expired_in,
  input wire logic        switch_stream_busy_out,
  input wire logic        rise_settle_pending_out,
  input wire logic        fall_settle_pending_out
);
  logic dir_q;

  // Direction of the running stream, kept so that the end of the stream can be judged.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      dir_q <= 1'b0;
    else if (stream_start_in)
      dir_q <= stream_dir_up_in;
  end

  // ************
  // Checks
  // ************
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  AST_RSVD: assert property (
    avs_read_in && avs_waitrequest_out && avs_address_in == 4'h0
    |=> !avs_waitrequest_out && avs_readdata_out[12]) else $error("reserved bit low");
  AST_RD_FLAGS: assert property (
    avs_read_in && !avs_waitrequest_out && avs_address_in == 4'h0
    |-> avs_readdata_out[11:9] == {$past(switch_stream_busy_out),
    $past(rise_settle_pending_out), $past(fall_settle_pending_out)}) else $error("flag read");
  AST_BUSY_SET: assert property (stream_start_in |=> switch_stream_busy_out)
    else $error("busy not set");
  AST_BUSY_CLR: assert property (
    stream_done_in && !stream_start_in |=> !switch_stream_busy_out)
    else $error("busy not cleared");
  AST_RISE_SET: assert property (
    $rose(rise_settle_pending_out) |-> $past(stream_done_in && dir_q))
    else $error("rise flag set without power-up stream end");
  AST_RISE_DIR: assert property (
    stream_done_in && dir_q |=> rise_settle_pending_out)
    else $error("rise flag not set at power-up stream end");
  AST_RISE_CLR: assert property (
    $fell(rise_settle_pending_out) |-> $past(rise_expired_in))
    else $error("rise flag cleared early");
  AST_RISE_EXP: assert property (
    rise_expired_in && !(stream_done_in && dir_q) |=> !rise_settle_pending_out)
    else $error("rise flag kept after expiry");
  AST_FALL_SET: assert property (
    $rose(fall_settle_pending_out) |-> $past(stream_done_in && !dir_q))
    else $error("fall flag set without power-down stream end");
  AST_FALL_DIR: assert property (
    stream_done_in && !dir_q |=> fall_settle_pending_out)
    else $error("fall flag not set at power-down stream end");
  AST_FALL_CLR: assert property (
    $fell(fall_settle_pending_out) |-> $past(fall_expired_in))
    else $error("fall flag cleared early");
  AST_FALL_EXP: assert property (
    fall_expired_in && !(stream_done_in && !dir_q) |=> !fall_settle_pending_out)
    else $error("fall flag kept after expiry");
  cover property ($fell(rise_settle_pending_out));
  cover property ($fell(fall_settle_pending_out));
  cover property (avs_read_in && !avs_waitrequest_out);
  cover property ($fell(switch_stream_busy_out));
endmodule : pss_status_properties

bind pss_status pss_status_properties u_chk (.clk_in, .rst_in, .avs_address_in, .avs_read_in,
  .avs_readdata_out, .avs_waitrequest_out, .stream_start_in, .stream_dir_up_in,
  .stream_done_in, .rise_expired_in, .fall_expired_in, .switch_stream_busy_out,
  .rise_settle_pending_out, .fall_settle_pending_out);

// file: bench/pss_switch_model.sv
// Serializer and settle timers seen from the status block.
// Assumes one stream at a time; gap_in sets shift and settle length.
`timescale 1ns/1ps
module pss_switch_model (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              rise_req_in,
  input  wire logic              fall_req_in,
  input  wire logic [7:0]        gap_in,
  output pss_pkg::pss_stream_ev_t ev_out
);
  logic                    up_q;
  logic [1:0]              phase_q;
  logic [7:0]              cnt_q;
  pss_pkg::pss_stream_ev_t nx;

  // Requests arriving mid-stream are dropped, as a busy serializer would.
  always_comb
  begin
    nx = '0;
    case (phase_q)
      2'h0:
      begin
        nx.start  = rise_req_in || fall_req_in;
        nx.dir_up = rise_req_in;
      end
      2'h1:
      begin
        nx.done = (cnt_q == 8'h00);
      end
      default:
      begin
        nx.rise_expired = (cnt_q == 8'h00) && up_q;
        nx.fall_expired = (cnt_q == 8'h00) && !up_q;
      end
    endcase
  end

  // The serializer shares the controller reset, so a reset aborts a running stream.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ev_out  <= '0;
      up_q    <= 1'b0;
      phase_q <= 2'h0;
      cnt_q   <= 8'h00;
    end
    else
    begin
      ev_out <= nx;
      if (phase_q == 2'h0)
      begin
        if (nx.start)
        begin
          up_q    <= rise_req_in;
          cnt_q   <= gap_in;
          phase_q <= 2'h1;
        end
      end
      else if (cnt_q == 8'h00)
      begin
        cnt_q   <= gap_in;
        phase_q <= (phase_q == 2'h1) ? 2'h2 : 2'h0;
      end
      else
      begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule : pss_switch_model

// file: bench/pss_status_tb.sv
// Self-checking bench for the status block.
// Assumes the switch model drives the stream events.
`timescale 1ns/1ps
module pss_status_tb;
  typedef struct packed {logic [1:0] cmd; logic [7:0] gap; logic up;} pss_row_t;
  logic                    clk_in = 1'b0;
  logic                    rst_in = 1'b1;
  logic [3:0]              addr = 4'h0;
  logic [3:0]              be = 4'h0;
  logic                    rd = 1'b0;
  logic                    wr = 1'b0;
  logic [31:0]             wd = 32'h0;
  logic [7:0]              gap = 8'h06;
  logic [31:0]             rdata, q;
  logic                    waitreq, rise_req, fall_req, busy, rise, fall;
  pss_pkg::pss_stream_ev_t ev;
  int                      n_fail = 0, compares = 0, reqs = 0;
  pss_row_t                rows [3];

  always #20 clk_in = ~clk_in;
  always @(posedge clk_in)
    if (rise_req === 1'b1 || fall_req === 1'b1)
      reqs++;

  pss_status uut (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .stream_start_in(ev.start), .stream_dir_up_in(ev.dir_up),
    .stream_done_in(ev.done), .rise_expired_in(ev.rise_expired),
    .fall_expired_in(ev.fall_expired), .rise_req_out(rise_req), .fall_req_out(fall_req),
    .switch_stream_busy_out(busy), .rise_settle_pending_out(rise),
    .fall_settle_pending_out(fall));
  pss_switch_model u_sw (.clk_in(clk_in), .rst_in(rst_in), .rise_req_in(rise_req),
    .fall_req_in(fall_req), .gap_in(gap), .ev_out(ev));

  // ************
  // Tasks
  // ************
  task automatic stop_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] r);
    int n;
    @(posedge clk_in);
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= d;
    be <= b;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (waitreq !== 1'b0 && n < 50);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50)
    begin
      chk({31'h0, waitreq}, 32'h0);
      stop_test();
    end
  endtask : bus

  task automatic wait_st(input logic [2:0] want);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while ({busy, rise, fall} !== want && n < 200);
    if (n >= 200)
    begin
      chk({29'h0, busy, rise, fall}, {29'h0, want});
      stop_test();
    end
  endtask : wait_st

  // ************
  // Sequence
  // ************
  initial
  begin
    rows[0] = '{2'h1, 8'h06, 1'b1};
    rows[1] = '{2'h2, 8'h0c, 1'b0};
    rows[2] = '{2'h3, 8'h1e, 1'b1};
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    chk({27'h0, rdata[0], waitreq, busy, rise, fall}, 32'h8);
    foreach (rows[i])
    begin
      gap <= rows[i].gap;
      bus(1'b1, 4'h4, {30'h0, rows[i].cmd}, 4'hf, q);
      wait_st(3'b100);
      bus(1'b0, 4'h0, 32'h0, 4'hf, q);
      chk(q, 32'h1800);
      wait_st({1'b0, rows[i].up, !rows[i].up});
      bus(1'b0, 4'h0, 32'h0, 4'hf, q);
      chk(q, rows[i].up ? 32'h1400 : 32'h1200);
      wait_st(3'b000);
      bus(1'b0, 4'h0, 32'h0, 4'hf, q);
      chk(q, 32'h1000);
      $display("row %0d done", i);
    end
    // A second command while the first is still shifting must be dropped.
    bus(1'b1, 4'h4, 32'h1, 4'hf, q);
    wait_st(3'b100);
    bus(1'b1, 4'h4, 32'h2, 4'hf, q);
    wait_st(3'b010);
    wait_st(3'b000);
    $display("busy command done");
    bus(1'b1, 4'h4, 32'h1, 4'he, q);
    bus(1'b1, 4'h0, 32'hffff_ffff, 4'hf, q);
    bus(1'b1, 4'h8, 32'h3, 4'hf, q);
    repeat (20) @(posedge clk_in);
    bus(1'b0, 4'h0, 32'h0, 4'hf, q);
    chk(q, 32'h1000);
    bus(1'b0, 4'h8, 32'h0, 4'hf, q);
    chk(q, 32'h0);
    bus(1'b0, 4'h4, 32'h0, 4'hf, q);
    chk(q, 32'h0);
    chk(32'(reqs), 32'h4);
    $display("refused writes done");
    bus(1'b1, 4'h4, 32'h2, 4'hf, q);
    wait_st(3'b100);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk({27'h0, rdata[0], waitreq, busy, rise, fall}, 32'h8);
    rst_in <= 1'b0;
    repeat (2)
    begin
      @(posedge clk_in);
      chk({27'h0, rdata[0], waitreq, busy, rise, fall}, 32'h8);
    end
    bus(1'b0, 4'h0, 32'h0, 4'hf, q);
    chk(q, 32'h1000);
    $display("mid reset done");
    stop_test();
  end
endmodule : pss_status_tb
